//--- verification/cfs_far_model.sv
// Far-side model: alarm input source and sync pulse source
`timescale 1ns/1ps
module cfs_far_model (
   input  wire logic pclk,     // Shared clock, used only to time changes
   output logic      in_line,  // Drives the general input line
   output logic      sync_pin  // Drives the sync input pin
);
   // Both lines rest low; the sync pin never floats between pulses
   initial begin
      in_line  = 1'b0;
      sync_pin = 1'b0;
   end
   // Level change of the input line, launched just after a clock edge
   task automatic set_line(input logic v);
      @(posedge pclk);
      in_line <= v;
   endtask : set_line
   // Sync pulse of w cycles; the rate is compressed to keep runs short
   task automatic pulse(input int w);
      @(posedge pclk);
      sync_pin <= 1'b1;
      repeat (w) @(posedge pclk);
      sync_pin <= 1'b0;
   endtask : pulse
endmodule : cfs_far_model

//--- verification/tb_top.sv
// Testbench: APB sequences against the I/O and frame sync block
`timescale 1ns/1ps
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        in_line, sync_pin, out_line, relay, frame_start, event_notify, irq;
   int          bad_count, samples_checked, cyc, n_frame, n_relay, n_event;

   cfs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .general_input_line(in_line), .sync_in(sync_pin),
      .general_output_line(out_line), .sync_relay_out(relay), .frame_start(frame_start),
      .event_notify(event_notify), .irq(irq));
   cfs_far_model far_u (.pclk(pclk), .in_line(in_line), .sync_pin(sync_pin));

   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; read data is compared only for reads
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic ee);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      chk($sformatf("error at %h", a), {31'h0, ee}, {31'h0, pslverr});
      if (!w) chk($sformatf("read at %h", a), exp, prdata);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : acc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0, exp, 1'b0);
   endtask : rd
   // Sync pulse followed by a settling gap longer than the stretch; rate compressed
   task automatic sync_pulse(input int w);
      far_u.pulse(w);
      repeat (250) @(posedge pclk);
   endtask : sync_pulse

   // Output monitors and the hang guard; cycle budget is far above the run
   always @(posedge pclk) begin
      cyc++;
      if (frame_start === 1'b1) n_frame++;
      if (relay === 1'b1) n_relay++;
      if (event_notify === 1'b1) n_event++;
      if (cyc == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(cfs_pkg::FILT_OFF, 32'h0);
      rd(cfs_pkg::SYNC_OFF, 32'h0);
      acc(1'b0, 8'hFC, 32'h0, 32'h0, 1'b1);
      $display("Reset values done");
      // Output line follows the setting both ways
      wr(cfs_pkg::OUT_OFF, 32'h1);
      repeat (2) @(posedge pclk);
      chk("output line", 32'h1, {31'h0, out_line});
      wr(cfs_pkg::OUT_OFF, 32'h0);
      repeat (2) @(posedge pclk);
      chk("output line", 32'h0, {31'h0, out_line});
      $display("Output line done");
      // Routed change: status, event and interrupt; then unrouted change
      wr(cfs_pkg::ROUTE_OFF, 32'h0000_0352);
      wr(cfs_pkg::MASK_OFF, 32'h1);
      n_event = 0;
      far_u.set_line(1'b1);
      repeat (8) @(posedge pclk);
      rd(cfs_pkg::IN_OFF, 32'h1);
      chk("events", 32'h1, n_event);
      chk("irq", 32'h1, {31'h0, irq});
      rd(cfs_pkg::STAT_OFF, 32'h1);
      wr(cfs_pkg::STAT_OFF, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(cfs_pkg::ROUTE_OFF, 32'h0000_0351);
      n_event = 0;
      far_u.set_line(1'b0);
      repeat (8) @(posedge pclk);
      rd(cfs_pkg::IN_OFF, 32'h0);
      chk("events", 32'h0, n_event);
      $display("Input events done");
      // Filter: width, glitch shorter than the window, then a held change
      wr(cfs_pkg::FILT_OFF, 32'h0001_FFFF);
      rd(cfs_pkg::FILT_OFF, 32'h0000_FFFF);
      wr(cfs_pkg::FILT_OFF, 32'h2);
      wr(cfs_pkg::ROUTE_OFF, 32'h0000_0352);
      n_event = 0;
      far_u.set_line(1'b1);
      repeat (60) @(posedge pclk);
      far_u.set_line(1'b0);
      repeat (250) @(posedge pclk);
      rd(cfs_pkg::IN_OFF, 32'h0);
      chk("events", 32'h0, n_event);
      far_u.set_line(1'b1);
      repeat (100) @(posedge pclk);
      rd(cfs_pkg::IN_OFF, 32'h0);
      repeat (150) @(posedge pclk);
      rd(cfs_pkg::IN_OFF, 32'h1);
      chk("events", 32'h1, n_event);
      wr(cfs_pkg::FILT_OFF, 32'h0);
      $display("Filter done");
      // Sync off, relaying leader, short pulse, follower, divided rate
      n_frame = 0;
      sync_pulse(25);
      chk("frames off", 32'h0, n_frame);
      wr(cfs_pkg::SYNC_OFF, 32'h2);
      n_frame = 0;
      n_relay = 0;
      sync_pulse(25);
      chk("frames", 32'h1, n_frame);
      chk("relay width", cfs_pkg::STRETCH_CYC, n_relay);
      n_frame = 0;
      sync_pulse(10);
      chk("short pulse", 32'h0, n_frame);
      wr(cfs_pkg::SYNC_OFF, 32'h1);
      n_frame = 0;
      n_relay = 0;
      sync_pulse(25);
      chk("frames", 32'h1, n_frame);
      chk("relay", 32'h0, n_relay);
      wr(cfs_pkg::SYNC_OFF, 32'h11);
      n_frame = 0;
      sync_pulse(25);
      sync_pulse(25);
      chk("divided frames", 32'h1, n_frame);
      rd(cfs_pkg::FRAME_OFF, 32'h3);
      rd(cfs_pkg::STAT_OFF, 32'h7);
      rd(cfs_pkg::ID_OFF, cfs_pkg::ID_VALUE);
      $display("Sync done");
      // Reset in mid-run drops the sync mode back to disabled
      wr(cfs_pkg::SYNC_OFF, 32'h2);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(cfs_pkg::SYNC_OFF, 32'h0);
      n_frame = 0;
      sync_pulse(25);
      chk("frames after reset", 32'h0, n_frame);
      $display("Mid-run reset done");
      stop_test();
   end
endmodule : tb_top

//--- verilog/cfs_pkg.sv
// Package: register map, field values, reset values and timing counts for the I/O and sync block
package cfs_pkg;
   // Register byte offsets
   localparam logic [7:0] OUT_OFF    = 8'h00;
   localparam logic [7:0] IN_OFF     = 8'h04;
   localparam logic [7:0] ROUTE_OFF  = 8'h08;
   localparam logic [7:0] FILT_OFF   = 8'h0C;
   localparam logic [7:0] SYNC_OFF   = 8'h10;
   localparam logic [7:0] STAT_OFF   = 8'h14;
   localparam logic [7:0] MASK_OFF   = 8'h18;
   localparam logic [7:0] FRAME_OFF  = 8'h1C;
   localparam logic [7:0] ID_OFF     = 8'h20;
   // Event route enumerations
   localparam logic [3:0] ROUTE_INPUT_LINE = 4'h2;
   localparam logic [3:0] SRC_INPUT_QUEUE  = 4'h5;
   localparam logic [3:0] DELIVERY_EVENT   = 4'h3;
   // Reset values
   localparam logic [15:0] FILT_RST  = 16'h0000;
   localparam logic [1:0]  SYNC_RST  = 2'h0;
   localparam logic [2:0]  MASK_RST  = 3'h0;
   localparam logic [3:0]  DIV_RST   = 4'h0;
   // Status bit positions
   localparam int ST_EDGE  = 0;
   localparam int ST_SYNC  = 1;
   localparam int ST_FRAME = 2;
   // Timing
   localparam int CLK_PS       = 5000;
   localparam int FILT_STEP_PS = 480000;
   localparam int FILT_STEP_CYC = (FILT_STEP_PS + CLK_PS - 1) / CLK_PS;
   localparam int MIN_PULSE_PS = 100000;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_PS + CLK_PS - 1) / CLK_PS;
   localparam int STRETCH_PS   = 1000000;
   localparam int STRETCH_CYC  = (STRETCH_PS + CLK_PS - 1) / CLK_PS;
   localparam logic [31:0] ID_VALUE = 32'h00C0FFEE; // Arbitrary value
   // Sync modes
   typedef enum logic [1:0] {
      CFS_SYNC_OFF    = 2'b00,
      CFS_SYNC_FOLLOW = 2'b01,
      CFS_SYNC_RELAY  = 2'b10,
      CFS_SYNC_LEAD   = 2'b11
   } cfs_sync_t;
endpackage : cfs_pkg

//--- verilog/cfs_top.sv
// General I/O line, debounced input events and frame sync channel with APB registers
// Operation
// - Output line follows output level setting
// - Input status reflects input line level
// - Input change raises notification when routed
// - Filter ignores transitions within setting times 480ns
// - Filter resets to zero; zero means pass-through
// - Filter setting is sixteen bits wide
// - Sync input aligns frame start
// - Pulses at least 100ns, stretched to 1us
// - Sync mode resets to disabled
// - Slow configuration uses fraction of pulse rate
// - Relaying leader forwards pulses, follower does not
`timescale 1ns/1ps
module cfs_top (
   input  wire logic        pclk,          // APB clock, 200 MHz
   input  wire logic        presetn,       // Async reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        general_input_line, // Async input pin
   input  wire logic        sync_in,       // Async sync pulse pin
   output logic             general_output_line, // Output pin
   output logic             sync_relay_out, // Relayed sync pulse
   output logic             frame_start,   // One-cycle frame start pulse
   output logic             event_notify,  // One-cycle change notification
   output logic             irq            // Level interrupt
);
   logic        out_reg;
   logic [3:0]  route_reg, src_reg, dlv_reg;
   logic [15:0] filt_reg;
   cfs_pkg::cfs_sync_t mode_reg;
   logic [3:0]  div_reg;
   logic [2:0]  stat_reg, mask_reg;
   logic [2:0]  in_sync_reg, sy_sync_reg;
   logic        in_state_reg;
   logic [15:0] filt_cnt_reg;
   logic [7:0]  step_cnt_reg;
   logic        sy_state_reg;
   logic [7:0]  sy_wid_reg;
   logic        sy_acc_reg;
   logic [7:0]  str_cnt_reg;
   logic [3:0]  div_cnt_reg;
   logic [15:0] frame_cnt_reg;
   logic        wr, rd, hit, in_edge, sy_acc, frame_ev, ev_route;
   logic [2:0]  stat_next;

   // Bus decode; zero wait states
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == cfs_pkg::OUT_OFF) || (a == cfs_pkg::IN_OFF) || (a == cfs_pkg::ROUTE_OFF)
            || (a == cfs_pkg::FILT_OFF) || (a == cfs_pkg::SYNC_OFF) || (a == cfs_pkg::STAT_OFF)
            || (a == cfs_pkg::MASK_OFF) || (a == cfs_pkg::FRAME_OFF) || (a == cfs_pkg::ID_OFF);
   endfunction : mapped
   assign hit = mapped(paddr);

   // Control registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg   <= 1'b0;
         route_reg <= 4'h0;
         src_reg   <= 4'h0;
         dlv_reg   <= 4'h0;
         filt_reg  <= cfs_pkg::FILT_RST;
         mode_reg  <= cfs_pkg::CFS_SYNC_OFF;
         div_reg   <= cfs_pkg::DIV_RST;
         mask_reg  <= cfs_pkg::MASK_RST;
      end else if (wr) begin
         if (paddr == cfs_pkg::OUT_OFF) begin
            out_reg <= pwdata[0];
         end else if (paddr == cfs_pkg::ROUTE_OFF) begin
            route_reg <= pwdata[3:0];
            src_reg   <= pwdata[7:4];
            dlv_reg   <= pwdata[11:8];
         end else if (paddr == cfs_pkg::FILT_OFF) begin
            filt_reg <= pwdata[15:0];
         end else if (paddr == cfs_pkg::SYNC_OFF) begin
            mode_reg <= cfs_pkg::cfs_sync_t'(pwdata[1:0]);
            div_reg  <= pwdata[7:4];
         end else if (paddr == cfs_pkg::MASK_OFF) begin
            mask_reg <= pwdata[2:0];
         end
      end
   end

   // Read mux; unmapped addresses answer with an error and zero data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= 32'h00000000;
         if (psel & ~penable & ~pwrite) begin
            if (paddr == cfs_pkg::OUT_OFF) begin
               prdata <= {31'h00000000, out_reg};
            end else if (paddr == cfs_pkg::IN_OFF) begin
               prdata <= {31'h00000000, in_state_reg};
            end else if (paddr == cfs_pkg::ROUTE_OFF) begin
               prdata <= {20'h00000, dlv_reg, src_reg, route_reg};
            end else if (paddr == cfs_pkg::FILT_OFF) begin
               prdata <= {16'h0000, filt_reg};
            end else if (paddr == cfs_pkg::SYNC_OFF) begin
               prdata <= {24'h000000, div_reg, 2'h0, mode_reg};
            end else if (paddr == cfs_pkg::STAT_OFF) begin
               prdata <= {29'h00000000, stat_reg};
            end else if (paddr == cfs_pkg::MASK_OFF) begin
               prdata <= {29'h00000000, mask_reg};
            end else if (paddr == cfs_pkg::FRAME_OFF) begin
               prdata <= {16'h0000, frame_cnt_reg};
            end else if (paddr == cfs_pkg::ID_OFF) begin
               prdata <= cfs_pkg::ID_VALUE;
            end
         end
      end
   end
   // Access phase lasts one cycle since pready rises on the setup edge
   logic unused_rd;
   assign unused_rd = rd;

   // Three-stage synchronisers; a change counts when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_sync_reg <= 3'h0;
         sy_sync_reg <= 3'h0;
      end else begin
         in_sync_reg <= {in_sync_reg[1:0], general_input_line};
         sy_sync_reg <= {sy_sync_reg[1:0], sync_in};
      end
   end

   // Debounce: new level must hold filt_reg steps of 480 ns; zero passes through
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_state_reg <= 1'b0;
         filt_cnt_reg <= 16'h0000;
         step_cnt_reg <= 8'h00;
      end else if (in_sync_reg[1] != in_sync_reg[2] || in_sync_reg[2] == in_state_reg) begin
         filt_cnt_reg <= 16'h0000;
         step_cnt_reg <= 8'h00;
      end else if (filt_reg == 16'h0000 || filt_cnt_reg == filt_reg) begin
         in_state_reg <= in_sync_reg[2];
         filt_cnt_reg <= 16'h0000;
         step_cnt_reg <= 8'h00;
      end else if (step_cnt_reg == 8'(cfs_pkg::FILT_STEP_CYC - 1)) begin
         step_cnt_reg <= 8'h00;
         filt_cnt_reg <= filt_cnt_reg + 16'h0001;
      end else begin
         step_cnt_reg <= step_cnt_reg + 8'h01;
      end
   end
   assign in_edge = (in_sync_reg[1] == in_sync_reg[2]) && (in_sync_reg[2] != in_state_reg)
                  && (filt_reg == 16'h0000 || filt_cnt_reg == filt_reg);
   assign ev_route = (route_reg == cfs_pkg::ROUTE_INPUT_LINE)
                   && (src_reg == cfs_pkg::SRC_INPUT_QUEUE)
                   && (dlv_reg == cfs_pkg::DELIVERY_EVENT);

   // Output line and change notification
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_output_line <= 1'b0;
         event_notify        <= 1'b0;
      end else begin
         general_output_line <= out_reg;
         event_notify        <= in_edge & ev_route;
      end
   end

   // Sync pulse width check: accept only pulses of at least 100 ns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy_state_reg <= 1'b0;
         sy_wid_reg   <= 8'h00;
         sy_acc_reg   <= 1'b0;
      end else begin
         if (sy_sync_reg[1] == sy_sync_reg[2]) begin
            sy_state_reg <= sy_sync_reg[2];
         end
         if (!sy_state_reg) begin
            sy_wid_reg <= 8'h00;
            sy_acc_reg <= 1'b0;
         end else if (sy_wid_reg != 8'hFF) begin
            sy_wid_reg <= sy_wid_reg + 8'h01;
         end
         if (sy_acc) begin
            sy_acc_reg <= 1'b1;
         end
      end
   end
   assign sy_acc = sy_state_reg && !sy_acc_reg && (mode_reg != cfs_pkg::CFS_SYNC_OFF)
                && (sy_wid_reg == 8'(cfs_pkg::MIN_PULSE_CYC - 1));

   // Stretch accepted pulse to 1 us; relay only in relaying leader mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         str_cnt_reg    <= 8'h00;
         sync_relay_out <= 1'b0;
      end else begin
         if (sy_acc) begin
            str_cnt_reg <= 8'(cfs_pkg::STRETCH_CYC);
         end else if (str_cnt_reg != 8'h00) begin
            str_cnt_reg <= str_cnt_reg - 8'h01;
         end
         sync_relay_out <= (mode_reg == cfs_pkg::CFS_SYNC_RELAY)
                         && (sy_acc || str_cnt_reg > 8'h01);
      end
   end

   // Frame start on every (div_reg+1)-th accepted pulse; slow configs use a divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg   <= 4'h0;
         frame_start   <= 1'b0;
         frame_cnt_reg <= 16'h0000;
      end else begin
         frame_start <= 1'b0;
         if (sy_acc) begin
            if (div_cnt_reg >= div_reg) begin
               div_cnt_reg   <= 4'h0;
               frame_start   <= 1'b1;
               frame_cnt_reg <= frame_cnt_reg + 16'h0001;
            end else begin
               div_cnt_reg <= div_cnt_reg + 4'h1;
            end
         end
      end
   end
   assign frame_ev = sy_acc && (div_cnt_reg >= div_reg);

   // Sticky status, write one to clear; set wins over clear
   always_comb begin
      stat_next = stat_reg;
      if (wr && paddr == cfs_pkg::STAT_OFF) begin
         stat_next = stat_next & ~pwdata[2:0];
      end
      stat_next[cfs_pkg::ST_EDGE]  = stat_next[cfs_pkg::ST_EDGE] | in_edge;
      stat_next[cfs_pkg::ST_SYNC]  = stat_next[cfs_pkg::ST_SYNC] | sy_acc;
      stat_next[cfs_pkg::ST_FRAME] = stat_next[cfs_pkg::ST_FRAME] | frame_ev;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= 3'h0;
         irq      <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         irq      <= |(stat_next & mask_reg);
      end
   end

   // Checks; multi-step behaviours are built from the named sequences below
   sequence frame_pulse_s;
      sy_acc && (div_reg == 4'h0);
   endsequence
   sequence relay_accept_s;
      sy_acc && (mode_reg == cfs_pkg::CFS_SYNC_RELAY);
   endsequence
   sequence relay_hold_s;
      mode_reg == cfs_pkg::CFS_SYNC_RELAY;
   endsequence

   // Bus answers one cycle after setup, with an error for holes in the map
   pready_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("ready missing after setup");
   slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !hit |=> pslverr)
      else $error("no error for unmapped address");
   bus_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !psel |=> !pready)
      else $error("ready while idle");

   // Output line follows the setting one cycle late
   out_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      out_reg |=> general_output_line)
      else $error("output line not asserted");
   out_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      !out_reg |=> !general_output_line)
      else $error("output line not low");

   // Input path: status, notification and filter
   notify_a: assert property (@(posedge pclk) disable iff (!presetn)
      event_notify |-> $changed(in_state_reg) && ev_route)
      else $error("bad notify");
   notify_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_edge && ev_route |=> event_notify)
      else $error("notify missing");
   notify_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ev_route |=> !event_notify)
      else $error("notify without route");
   in_status_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_edge |=> in_state_reg == $past(in_sync_reg[2]))
      else $error("status not updated");
   in_agree_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(in_state_reg) |-> $past(in_sync_reg[1]) == $past(in_sync_reg[2]))
      else $error("status took unsettled stage");
   filt_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      (filt_reg == 16'h0000 && in_sync_reg[1] == in_sync_reg[2] && in_sync_reg[2] != in_state_reg)
      |=> in_state_reg == $past(in_sync_reg[2]))
      else $error("no pass-through");
   filt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (filt_reg != 16'h0000 && filt_cnt_reg == 16'h0000 && step_cnt_reg == 8'h00)
      |=> $stable(in_state_reg))
      else $error("filter let change early");

   // Sticky status and the level interrupt; set wins over a same-cycle clear
   stat_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_edge |=> stat_reg[cfs_pkg::ST_EDGE])
      else $error("change status not set");
   stat_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
      sy_acc |=> stat_reg[cfs_pkg::ST_SYNC])
      else $error("sync status not set");
   irq_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      |(stat_next & mask_reg) |=> irq)
      else $error("interrupt missing");
   irq_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(|(stat_next & mask_reg)) |=> !irq)
      else $error("interrupt without cause");

   // Sync channel: stretch, relay, frame start and divider
   relay_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_reg != cfs_pkg::CFS_SYNC_RELAY |=> !sync_relay_out)
      else $error("relay leak");
   relay_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      relay_accept_s |=> sync_relay_out)
      else $error("relay did not start");
   stretch_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      sy_acc |=> str_cnt_reg == 8'(cfs_pkg::STRETCH_CYC))
      else $error("stretch not loaded");
   stretch_a: assert property (@(posedge pclk) disable iff (!presetn)
      relay_accept_s ##1 relay_hold_s |-> sync_relay_out [*8])
      else $error("relay pulse short");
   frame_a: assert property (@(posedge pclk) disable iff (!presetn)
      frame_pulse_s |=> frame_start)
      else $error("frame start missing");
   frame_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      sy_acc && (div_cnt_reg < div_reg) |=> !frame_start)
      else $error("frame start on skipped pulse");
   sync_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_reg == cfs_pkg::CFS_SYNC_OFF |-> !sy_acc)
      else $error("sync while disabled");
endmodule : cfs_top
